/* mic_pkg.sv */
// Package for the miscellaneous interrupt and clock control bank
package mic_pkg;
   localparam logic [7:0] REG_SENSE_CLK = 8'h20;
   localparam logic [7:0] REG_POL_TONE = 8'h40;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h60;
   localparam logic [7:0] REG_IRQ_MASK = 8'h64;
   localparam logic [7:0] REG_PIN_STATUS = 8'h68;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   // Field positions of the sense/clock register
   localparam int B_EDGE_B = 6;
   localparam int B_OSC_HALF = 5;
   localparam int B_EDGE_A = 3;
   localparam int B_DIV = 1;
   localparam int B_SLOW = 0;
   // Field positions of the polarity/tone register
   localparam int B_INV_A = 7;
   localparam int B_INV_B = 6;
   localparam int B_TONE = 4;
   localparam int B_TOP_EDGE = 3;
   localparam int B_TOP_EN = 2;
   localparam int B_SS_MODE = 1;
   localparam int B_SS_LEVEL = 0;
   localparam logic [1:0] IRQ_LEVEL_3 = 2'h3;
   // Tone timing: clock counts per half period at 20 MHz (~2 kHz, 1 kHz, 500 Hz)
   localparam int OSC_HZ = 20_000_000;
   localparam int TONE_2K_HZ = 2000;
   localparam logic [15:0] TONE_HALF_2K = 16'(OSC_HZ / (2 * TONE_2K_HZ));
   localparam logic [15:0] TONE_HALF_1K = 16'(OSC_HZ / TONE_2K_HZ);
   localparam logic [15:0] TONE_HALF_500 = 16'(2 * OSC_HZ / TONE_2K_HZ);
   typedef enum logic [1:0] {
      SENSE_FALL_LOW = 2'b00,
      SENSE_RISE = 2'b01,
      SENSE_FALL = 2'b10,
      SENSE_BOTH = 2'b11
   } mic_sense_t;
   typedef enum logic [1:0] {
      TONE_OFF = 2'b00,
      TONE_2K = 2'b01,
      TONE_1K = 2'b10,
      TONE_500 = 2'b11
   } mic_tone_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [7:0] dat;
   } mic_wb_req_t;
endpackage : mic_pkg

/* mic_misc_ctrl.sv */
// Miscellaneous interrupt sensitivity, clock, tone and select control bank
// What this block does
// [R1] Group-B sense field sets trigger of external interrupt groups two and three.
// [R2] Group-B invert flips group two trigger; both-edges stays both edges.
// [R3] Group-A sense field sets trigger of groups zero and one, same encodings.
// [R4] Group-A invert flips group zero trigger only; group one never inverted.
// [R5] Rising-plus-high-level exists only for groups zero and two.
// [R6] Sense fields accept writes only while interrupt level bits both equal one.
// [R7] Clock-out enable drives oscillator half rate on pin, else pin stays GPIO.
// [R8] Clock-out is stopped during active-halt even when enabled.
// [R9] Slow select off gives osc/2; on, divider field picks /4,/8,/16,/32.
// [R10] Tone select: off, ~2 kHz, ~1 kHz, ~500 Hz, about half duty.
// [R11] Tone keeps running during active-halt when enabled.
// [R12] Top-level edge bit picks falling or rising; writable only with enable clear.
// [R13] Top-level enable turns the dedicated pin's interrupt on or off.
// [R14] Clearing top-level enable may raise one spurious interrupt.
// [R15] Select-source bit picks external select pin or software level bit.
// [R16] External pin events interrupt only if pin configured as interrupt and core unmasked.
// [R17] Pins synchronised before edge detect; level mode holds request while level persists.
// [R18] Core clock divider changes only at an output period boundary.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mic_misc_ctrl
   import mic_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Core state
   input wire logic irq_level_bit_hi_i,
   input wire logic irq_level_bit_lo_i,
   input wire logic core_irq_mask_i,
   input wire logic active_halt_i,
   // External interrupt pins and their interrupt-input configuration
   input wire logic ext_irq_0_i,
   input wire logic ext_irq_1_i,
   input wire logic ext_irq_2_i,
   input wire logic ext_irq_3_i,
   input wire logic [3:0] ext_irq_cfg_i,
   input wire logic top_level_irq_pin_i,
   input wire logic select_line_gpio_i,
   // Interrupt requests to the core
   output logic [3:0] ext_irq_req_o,
   output logic top_irq_req_o,
   // Alternate pin functions
   output logic clock_out_pin_o,
   output logic clock_out_pin_oe_o,
   output logic tone_pin_o,
   output logic tone_pin_oe_o,
   output logic spi_select_o,
   output logic core_clk_en_o,
   // Block interrupt
   output logic irq_o
);
   logic [7:0] sense_clk;
   logic [7:0] pol_tone;
   logic [4:0] sts;
   logic [4:0] msk;
   logic [4:0] sync1, sync2, prev;
   logic [4:0] div_cnt;
   logic [4:0] div_max;
   logic osc_half;
   logic [15:0] tone_cnt;
   logic tone_lvl;
   logic top_en_d;

   function automatic logic trig(input logic [1:0] sense, input logic inv, input logic cur, input logic old);
      logic rise;
      logic fall;
      rise = cur & ~old;
      fall = ~cur & old;
      unique case (mic_sense_t'(sense))
         SENSE_FALL_LOW: trig = inv ? (rise | cur) : (fall | ~cur);
         SENSE_RISE: trig = inv ? fall : rise;
         SENSE_FALL: trig = inv ? rise : fall;
         SENSE_BOTH: trig = rise | fall;
      endcase
   endfunction : trig

   mic_wb_req_t req;
   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, dat: wb_dat_i[7:0]};
   wire access = req.cyc & req.stb & ~wb_ack_o;
   wire wr_lane = access & req.we & wb_sel_i[0];
   wire wr_sc = wr_lane && req.adr == REG_SENSE_CLK;
   wire wr_pt = wr_lane && req.adr == REG_POL_TONE;
   wire wr_msk = wr_lane && req.adr == REG_IRQ_MASK;
   wire rd_sts = access && !req.we && req.adr == REG_IRQ_STATUS;
   wire level3 = {irq_level_bit_hi_i, irq_level_bit_lo_i} == IRQ_LEVEL_3;
   wire [1:0] edge_b = level3 ? req.dat[B_EDGE_B+:2] : sense_clk[B_EDGE_B+:2]; // R6
   wire [1:0] edge_a = level3 ? req.dat[B_EDGE_A+:2] : sense_clk[B_EDGE_A+:2]; // R6
   wire top_edge_keep = pol_tone[B_TOP_EN] ? pol_tone[B_TOP_EDGE] : req.dat[B_TOP_EDGE]; // R12
   wire [7:0] next_sc = {edge_b, req.dat[B_OSC_HALF], edge_a, req.dat[B_DIV+:2], req.dat[B_SLOW]};
   wire [7:0] next_pt = {req.dat[7:4], top_edge_keep, req.dat[2:0]};

   // Inputs of the edge logic, second sync stage only
   wire [1:0] sa = sense_clk[B_EDGE_A+:2];
   wire [1:0] sb = sense_clk[B_EDGE_B+:2];
   wire hit0 = trig(sa, pol_tone[B_INV_A], sync2[0], prev[0]); // R3 R4 R5
   wire hit1 = trig(sa, 1'b0, sync2[1], prev[1]); // R3 R4
   wire hit2 = trig(sb, pol_tone[B_INV_B], sync2[2], prev[2]); // R1 R2 R5
   wire hit3 = trig(sb, 1'b0, sync2[3], prev[3]); // R1
   wire [3:0] ext_hit = {hit3, hit2, hit1, hit0} & ext_irq_cfg_i & {4{~core_irq_mask_i}}; // R16
   wire top_edge_hit = pol_tone[B_TOP_EDGE] ? (sync2[4] & ~prev[4]) : (~sync2[4] & prev[4]); // R12
   // Spurious request on clearing the enable mirrors the real part
   wire top_hit = (pol_tone[B_TOP_EN] & top_edge_hit) | (top_en_d & ~pol_tone[B_TOP_EN]); // R13 R14
   wire [4:0] events = {top_hit, ext_hit};

   // Divider: period in osc cycles minus one, taken only at wrap
   wire [1:0] dsel = sense_clk[B_DIV+:2];
   wire [4:0] slow_max = dsel == 2'b00 ? 5'h03 : dsel == 2'b10 ? 5'h07 : dsel == 2'b01 ? 5'h0f : 5'h1f; // R9
   wire [4:0] next_div_max = sense_clk[B_SLOW] ? slow_max : 5'h01; // R9
   wire div_wrap = div_cnt == div_max;

   mic_tone_t tone;
   assign tone = mic_tone_t'(pol_tone[B_TONE+:2]);
   logic [15:0] tone_half;
   always_comb begin
      unique case (tone)
         TONE_OFF: tone_half = TONE_HALF_2K;
         TONE_2K: tone_half = TONE_HALF_2K;
         TONE_1K: tone_half = TONE_HALF_1K;
         TONE_500: tone_half = TONE_HALF_500;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sense_clk <= RESET_VALUE;
         pol_tone <= RESET_VALUE;
         msk <= '0;
      end else begin
         if (wr_sc) sense_clk <= next_sc;
         if (wr_pt) pol_tone <= next_pt;
         if (wr_msk) msk <= req.dat[4:0];
      end
   end

   // Set wins over the read clear
   always_ff @(posedge clk_i) begin
      if (rst_i) sts <= '0;
      else sts <= (rd_sts ? 5'h00 : sts) | events;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
         top_en_d <= 1'b0;
      end else begin
         sync1 <= {top_level_irq_pin_i, ext_irq_3_i, ext_irq_2_i, ext_irq_1_i, ext_irq_0_i}; // R17
         sync2 <= sync1; // R17
         prev <= sync2;
         top_en_d <= pol_tone[B_TOP_EN];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= '0;
         div_max <= 5'h01;
         core_clk_en_o <= 1'b0;
      end else begin
         div_cnt <= div_wrap ? 5'h00 : div_cnt + 5'h01;
         if (div_wrap) div_max <= next_div_max; // R18
         core_clk_en_o <= div_wrap; // R9
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_half <= 1'b0;
         tone_cnt <= '0;
         tone_lvl <= 1'b0;
      end else begin
         osc_half <= ~osc_half;
         if (tone == TONE_OFF) begin
            tone_cnt <= '0;
            tone_lvl <= 1'b0;
         end else if (tone_cnt >= tone_half - 16'h0001) begin // R10 R11
            tone_cnt <= '0;
            tone_lvl <= ~tone_lvl;
         end else begin
            tone_cnt <= tone_cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         irq_o <= 1'b0;
         ext_irq_req_o <= '0;
         top_irq_req_o <= 1'b0;
         clock_out_pin_o <= 1'b0;
         clock_out_pin_oe_o <= 1'b0;
         tone_pin_o <= 1'b0;
         tone_pin_oe_o <= 1'b0;
         spi_select_o <= 1'b1;
      end else begin
         wb_ack_o <= access;
         wb_dat_o <= '0;
         if (access && !req.we) begin
            unique case (req.adr)
               REG_SENSE_CLK: wb_dat_o <= {24'h0, sense_clk};
               REG_POL_TONE: wb_dat_o <= {24'h0, pol_tone};
               REG_IRQ_STATUS: wb_dat_o <= {27'h0, sts};
               REG_IRQ_MASK: wb_dat_o <= {27'h0, msk};
               REG_PIN_STATUS: wb_dat_o <= {27'h0, sync2};
               default: wb_dat_o <= '0;
            endcase
         end
         irq_o <= |(((rd_sts ? 5'h00 : sts) | events) & msk);
         ext_irq_req_o <= ext_hit; // R17
         top_irq_req_o <= top_hit;
         clock_out_pin_o <= sense_clk[B_OSC_HALF] & ~active_halt_i & ~osc_half; // R7 R8
         clock_out_pin_oe_o <= sense_clk[B_OSC_HALF]; // R7
         tone_pin_o <= tone_lvl; // R11
         tone_pin_oe_o <= tone != TONE_OFF; // R10
         spi_select_o <= pol_tone[B_SS_MODE] ? pol_tone[B_SS_LEVEL] : select_line_gpio_i; // R15
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_sense_lock: assert property (wr_sc && !level3 |=> $stable(sense_clk[7:6]) && $stable(sense_clk[4:3])) // R6
      else $error("sense field changed outside level 3");
   a_top_edge_lock: assert property (wr_pt && pol_tone[B_TOP_EN] |=> pol_tone[B_TOP_EDGE] == $past(pol_tone[B_TOP_EDGE])) // R12
      else $error("top edge changed while enabled");
   a_spurious_top: assert property ($fell(pol_tone[B_TOP_EN]) |=> top_irq_req_o) // R14
      else $error("no request on top enable clear");
   a_clkout_halt: assert property (active_halt_i |=> !clock_out_pin_o) // R8
      else $error("clock out active in halt");
   a_clkout_off: assert property (!sense_clk[B_OSC_HALF] |=> !clock_out_pin_oe_o) // R7
      else $error("clock out driven while disabled");
   a_ss_select: assert property (pol_tone[B_SS_MODE] |=> spi_select_o == $past(pol_tone[B_SS_LEVEL])) // R15
      else $error("select not from soft bit");
   a_mask_gate: assert property (core_irq_mask_i |=> ext_irq_req_o == 4'h0) // R16
      else $error("request while masked");
   a_level_hold: assert property (sense_clk[4:3] == 2'b00 && !pol_tone[B_INV_A] && !sync2[0] && ext_irq_cfg_i[0]
      && !core_irq_mask_i |=> ext_irq_req_o[0]) // R17
      else $error("low level not held");
   a_div_normal: assert property (div_max == 5'h01 && next_div_max == 5'h01 && div_wrap // R9 R18
      |=> ##1 !core_clk_en_o ##1 core_clk_en_o)
      else $error("normal divider not osc/2");
   a_tone_off: assert property (tone == TONE_OFF |=> !tone_pin_oe_o) // R10
      else $error("tone driven while off");
   a_sense_write: assert property (wr_sc && level3 |=> sense_clk[7:6] == $past(req.dat[7:6])) // R6
      else $error("sense field not written at level 3");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (access |=> wb_ack_o)
      else $error("request not acknowledged");
   a_status_clear: assert property (rd_sts |=> sts == $past(events))
      else $error("status not cleared by read");
   a_irq_level: assert property ($stable(msk) |-> irq_o == |(sts & msk))
      else $error("irq out of step with status");
   a_tone_halt: assert property (tone != TONE_OFF && active_halt_i |=> tone_pin_oe_o) // R11
      else $error("tone stopped in halt");
   a_ss_pin: assert property (!pol_tone[B_SS_MODE] |=> spi_select_o == $past(select_line_gpio_i)) // R15
      else $error("select not from pin");
   a_top_quiet: assert property (!pol_tone[B_TOP_EN] && !top_en_d |=> !top_irq_req_o) // R13
      else $error("top request while disabled");
   a_cfg_gate: assert property (ext_irq_cfg_i == 4'h0 |=> ext_irq_req_o == 4'h0) // R16
      else $error("request from pin not set as interrupt");
   a_div_pulse: assert property (core_clk_en_o |=> !core_clk_en_o) // R9
      else $error("core enable wider than one cycle");
   c_ext_irq: cover property (ext_irq_req_o[0]);
   c_top_irq: cover property (top_irq_req_o);
   c_slow: cover property (div_max == 5'h1f && core_clk_en_o);
   c_tone: cover property ($rose(tone_pin_o));
   c_spurious: cover property ($fell(pol_tone[B_TOP_EN]) ##1 top_irq_req_o);
endmodule : mic_misc_ctrl
`default_nettype wire

/* mic_core_model.sv */
// Core-side model: classic Wishbone master and the core interrupt level bits
`timescale 1ns/1ps
`default_nettype none
module mic_core_model (
   // Clock
   input wire logic clk_i,
   // Wishbone master
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_i,
   // Core interrupt level
   output logic irq_level_bit_hi_o,
   output logic irq_level_bit_lo_o
);
   initial begin
      {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
      {irq_level_bit_hi_o, irq_level_bit_lo_o} = 2'h0;
   end
   // Software moves the sense fields only at level 3
   task automatic set_level(input logic [1:0] lvl);
      @(posedge clk_i);
      {irq_level_bit_hi_o, irq_level_bit_lo_o} <= lvl;
   endtask : set_level
   task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [7:0] rd);
      @(posedge clk_i);
      {wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, we};
      wb_adr_o <= adr;
      wb_sel_o <= 4'h1;
      wb_dat_o <= {24'h000000, dat};
      // No cycle budget of its own: the bench watchdog ends a hang
      do begin
         @(posedge clk_i);
      end while (wb_ack_i !== 1'b1);
      rd = wb_dat_i[7:0];
      {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'b000;
      // Released lines must not keep looking valid
      wb_adr_o <= ~adr;
      wb_dat_o <= ~{24'h000000, dat};
   endtask : bus
endmodule : mic_core_model
`default_nettype wire

/* mic_tb_top.sv */
// Self-checking bench for the miscellaneous control bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import mic_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, hi, lo, cmask = 1'b0, halt = 1'b0, sel_pin = 1'b1;
   logic top_req, ck_out, ck_oe, tone, tone_oe, spi_sel, clk_en, irq;
   logic [7:0] adr;
   logic [3:0] sel, cfg = 4'hf, req;
   logic [4:0] pin_v = 5'h00;
   logic [31:0] wdat, rdat;
   int n_fail = 0;
   int checks_done = 0;
   always #25 clk_i = ~clk_i;
   mic_core_model core (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
      .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack), .irq_level_bit_hi_o(hi),
      .irq_level_bit_lo_o(lo));
   mic_misc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_level_bit_hi_i(hi), .irq_level_bit_lo_i(lo), .core_irq_mask_i(cmask), .active_halt_i(halt),
      .ext_irq_0_i(pin_v[0]), .ext_irq_1_i(pin_v[1]), .ext_irq_2_i(pin_v[2]), .ext_irq_3_i(pin_v[3]),
      .ext_irq_cfg_i(cfg), .top_level_irq_pin_i(pin_v[4]), .select_line_gpio_i(sel_pin),
      .ext_irq_req_o(req), .top_irq_req_o(top_req), .clock_out_pin_o(ck_out), .clock_out_pin_oe_o(ck_oe),
      .tone_pin_o(tone), .tone_pin_oe_o(tone_oe), .spi_select_o(spi_sel), .core_clk_en_o(clk_en),
      .irq_o(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      core.bus(1'b1, a, d, r);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      core.bus(1'b0, a, 8'h00, r);
      chk(32'(r), 32'(e));
   endtask : rd_chk
   task automatic settle;
      repeat (3) @(posedge clk_i);
      #1;
   endtask : settle
   // Pin change, then count request pulses over the sync latency
   task automatic pulses(input int idx, input logic v, input logic [31:0] e);
      int c;
      logic [4:0] seen;
      c = 0;
      @(posedge clk_i);
      pin_v[idx] <= v;
      repeat (8) begin
         @(posedge clk_i);
         #1;
         seen = {top_req, req};
         if (seen[idx] === 1'b1) c++;
      end
      chk(32'(c), e);
   endtask : pulses
   task automatic wait_en(output int n);
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (clk_en !== 1'b1 && n < 100);
   endtask : wait_en
   task automatic t_reset;
      chk(32'(spi_sel), 32'h1);
      rd_chk(REG_SENSE_CLK, RESET_VALUE);
      rd_chk(REG_POL_TONE, RESET_VALUE);
      rd_chk(8'h10, 8'h00);
   endtask : t_reset
   task automatic t_sense_div;
      logic [7:0] cv [5] = '{8'h00, 8'h01, 8'h05, 8'h03, 8'h07};
      int ev [5] = '{2, 4, 8, 16, 32};
      int n;
      wr(REG_SENSE_CLK, 8'hff);
      rd_chk(REG_SENSE_CLK, 8'h27);
      core.set_level(IRQ_LEVEL_3);
      wr(REG_SENSE_CLK, 8'hff);
      rd_chk(REG_SENSE_CLK, 8'hff);
      foreach (cv[i]) begin
         wr(REG_SENSE_CLK, cv[i]);
         repeat (70) @(posedge clk_i);
         wait_en(n);
         wait_en(n);
         chk(32'(n), 32'(ev[i]));
      end
   endtask : t_sense_div
   task automatic t_clk_out;
      logic p;
      wr(REG_SENSE_CLK, 8'h20);
      settle();
      p = ck_out;
      @(posedge clk_i);
      #1;
      chk(32'({ck_oe, ck_out}), 32'({1'b1, ~p}));
      @(posedge clk_i);
      halt <= 1'b1;
      settle();
      chk(32'({ck_oe, ck_out}), 32'h2);
      @(posedge clk_i);
      #1;
      chk(32'(ck_out), 32'h0);
      wr(REG_SENSE_CLK, 8'h00);
      settle();
      chk(32'(ck_oe), 32'h0);
   endtask : t_clk_out
   // Every tone mode, still in active-halt; the first toggle only aligns
   task automatic t_tone;
      logic [15:0] hp [3] = '{TONE_HALF_2K, TONE_HALF_1K, TONE_HALF_500};
      logic p;
      int n;
      foreach (hp[m]) begin
         wr(REG_POL_TONE, 8'((m + 1) << B_TONE));
         for (int k = 0; k < 2; k++) begin
            p = tone;
            n = 0;
            do begin
               @(posedge clk_i);
               #1;
               n++;
            end while (tone === p && n < 30000);
         end
         chk(32'({tone_oe, 16'(n)}), 32'({1'b1, hp[m]}));
      end
      wr(REG_POL_TONE, 8'h00);
      halt <= 1'b0;
      settle();
      chk(32'(tone_oe), 32'h0);
   endtask : t_tone
   task automatic t_select;
      wr(REG_POL_TONE, 8'h02);
      settle();
      chk(32'(spi_sel), 32'h0);
      @(posedge clk_i);
      sel_pin <= 1'b0;
      wr(REG_POL_TONE, 8'h03);
      settle();
      chk(32'(spi_sel), 32'h1);
      wr(REG_POL_TONE, 8'h00);
      settle();
      chk(32'(spi_sel), 32'h0);
   endtask : t_select
   task automatic t_top;
      logic [7:0] r;
      cfg <= 4'h0;
      wr(REG_IRQ_MASK, 8'h1f);
      core.bus(1'b0, REG_IRQ_STATUS, 8'h00, r);
      wr(REG_POL_TONE, 8'h04);
      pulses(4, 1'b1, 0);
      pulses(4, 1'b0, 1);
      chk(32'(irq), 32'h1);
      rd_chk(REG_IRQ_STATUS, 8'h10);
      settle();
      chk(32'(irq), 32'h0);
      wr(REG_POL_TONE, 8'h0c);
      rd_chk(REG_POL_TONE, 8'h04);
      wr(REG_POL_TONE, 8'h00);
      rd_chk(REG_IRQ_STATUS, 8'h10);
      wr(REG_IRQ_MASK, 8'h00);
      wr(REG_POL_TONE, 8'h04);
      pulses(4, 1'b1, 0);
      pulses(4, 1'b0, 1);
      chk(32'(irq), 32'h0);
      rd_chk(REG_IRQ_STATUS, 8'h10);
   endtask : t_top
   task automatic t_ext;
      @(posedge clk_i);
      cfg <= 4'hf;
      wr(REG_SENSE_CLK, 8'h08);
      wr(REG_POL_TONE, 8'h00);
      pulses(0, 1'b1, 1);
      pulses(0, 1'b0, 0);
      wr(REG_POL_TONE, 8'h80);
      pulses(0, 1'b1, 0);
      pulses(0, 1'b0, 1);
      pulses(1, 1'b1, 1);
      pulses(1, 1'b0, 0);
      @(posedge clk_i);
      cmask <= 1'b1;
      pulses(1, 1'b1, 0);
      @(posedge clk_i);
      cmask <= 1'b0;
      cfg <= 4'he;
      pulses(0, 1'b1, 0);
      pulses(0, 1'b0, 0);
      chk(32'(req[3:2]), 32'h3);
      wr(REG_POL_TONE, 8'h40);
      settle();
      chk(32'(req[3:2]), 32'h2);
   endtask : t_ext
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   initial begin
      // Tests need about 72k cycles, mostly the slow tones
      #4_500_000;
      n_fail++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      t_reset();
      t_top();
      t_sense_div();
      t_clk_out();
      t_tone();
      t_select();
      t_ext();
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
